// [core/mpc_pkg.sv]
// Package: field layout, reset values and timing counts of the mode/pin config register
package mpc_pkg;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int WAKE_EDGE_LSB    = 30;
    localparam int WD_PERIOD_LSB    = 28;
    localparam int REF_FREQ_BIT     = 27;
    localparam int OUT2_SRC_LSB     = 22;
    localparam int TEST_EN_BIT      = 21;
    localparam int RAIL_SEL_BIT     = 19;
    localparam int WD_KICK_BIT      = 18;
    localparam int WD_ACT_LSB       = 16;
    localparam int PIN1_FUNC_LSB    = 14;
    localparam int FAIL_SAFE_BIT    = 13;
    localparam int PIN1_SRC_LSB     = 10;
    localparam int SLEEP_OFF_BIT    = 9;
    localparam int WAKE_FUNC_BIT    = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] WAKE_EDGE_RST = 2'h3;
    localparam logic [1:0] WD_PERIOD_RST = 2'h0;
    localparam logic       REF_FREQ_RST  = 1'h1;
    localparam logic [1:0] OUT2_SRC_RST  = 2'h0;
    localparam logic [1:0] PIN1_SRC_RST  = 2'h1;
    localparam logic [1:0] PIN1_FUNC_RST = 2'h0;
    localparam logic [1:0] WD_ACT_RST    = 2'h0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] OUT2_NONE = 2'h0;
    localparam logic [1:0] OUT2_CAN0 = 2'h1;
    localparam logic [1:0] OUT2_WDOG = 2'h2;
    localparam logic [1:0] OUT2_IRQ  = 2'h3;
    localparam logic [1:0] ACT_FLAG  = 2'h0;
    localparam logic [1:0] ACT_SLEEP = 2'h1;
    localparam logic [1:0] ACT_PIN   = 2'h2;
    localparam logic [1:0] PIN1_OUT  = 2'h0;
    localparam logic [1:0] PIN1_TRIG = 2'h2;
    localparam logic [1:0] SRC_SPI   = 2'h0;
    localparam logic [1:0] SRC_CAN1  = 2'h1;
    localparam logic [1:0] SRC_UVT   = 2'h2;

    // ------------------------------------------------------------------
    // Timing: times in ms, counts in cycles at 100 MHz
    // ------------------------------------------------------------------
    localparam longint CLK_HZ       = 100_000_000;
    localparam longint WD_MS_0      = 60;
    localparam longint WD_MS_1      = 600;
    localparam longint WD_MS_2      = 3000;
    localparam longint WD_MS_3      = 6000;
    localparam longint PULSE_MS     = 300;
    localparam longint WD_CYC_0     = WD_MS_0 * CLK_HZ / 1000;
    localparam longint WD_CYC_1     = WD_MS_1 * CLK_HZ / 1000;
    localparam longint WD_CYC_2     = WD_MS_2 * CLK_HZ / 1000;
    localparam longint WD_CYC_3     = WD_MS_3 * CLK_HZ / 1000;
    localparam longint PULSE_CYC    = PULSE_MS * CLK_HZ / 1000;

    // Pulse generator states
    typedef enum logic [1:0] {
        MPC_IDLE  = 2'b00,
        MPC_PULSE = 2'b01
    } mpc_pulse_e;

endpackage

// [core/mpc_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mpc_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // ------------------------------------------------------------------
    // Sync chain; first stage read only by second
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // mpc_sync

// [core/mpc_pulse.sv]
// Low pulse generator of fixed length
`timescale 1ns/1ps
module mpc_pulse import mpc_pkg::*; #(
    parameter longint LEN = PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic start,
    output logic      low_q
);
    mpc_pulse_e  st_q;
    logic [31:0] cnt_q;
    wire         last = (cnt_q == 32'(LEN - 1));

    // ------------------------------------------------------------------
    // Hold output low for LEN cycles after start
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q  <= MPC_IDLE;
            cnt_q <= 32'h0;
            low_q <= 1'b0;
        end else begin
            case (st_q)
                MPC_IDLE: begin
                    cnt_q <= 32'h0;
                    low_q <= start;
                    if (start) st_q <= MPC_PULSE;
                end
                MPC_PULSE: begin
                    cnt_q <= cnt_q + 32'h1;
                    low_q <= !last;
                    if (last) st_q <= MPC_IDLE;
                end
                default: st_q <= MPC_IDLE;
            endcase
        end
    end
endmodule // mpc_pulse

// [core/mpc_config.sv]
// Mode-and-pin configuration register, upper fields, with watchdog
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) Wake edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// (RULE_02) Watchdog period 00=60ms 01=600ms 10=3s 11=6s; resets to 00.
// (RULE_03) Reference frequency bit: 0 is 20 MHz, 1 is 40 MHz; resets to 1.
// (RULE_04) Out pin two: none, CAN line 0, watchdog, or irq copy; reset 00.
// (RULE_05) Test enable bit 21 holds test mode while set; resets to 0.
// (RULE_06) Bit 19 picks wake-request buffer rail: internal or I/O; reset 0.
// (RULE_07) Writing 1 to kick bit 18 restarts watchdog; bit self-clears.
// (RULE_08) On expiry the kick bit is set then the timeout action runs.
// (RULE_09) Action 00 sets flag and drives watchdog-irq pins low; 11 reserved.
// (RULE_10) Action 01 pulses inhibit ~300ms, goes standby; 10 pulses wdog pin.
// (RULE_11) The watchdog interrupt flag is set on every timeout.
// (RULE_12) Pin one function: 00 general output, 10 watchdog trigger input.
// (RULE_13) Bit 13 enables fail-safe mode; power-up fail-safe is unaffected.
// (RULE_14) Pin one source: SPI fault, CAN line 1, or UV/thermal; reset 01.
// (RULE_15) Bit 9 disables the inhibit output when set; resets to 0.
// (RULE_16) Bit 8: wake-request copies inhibit (0) or is a wake irq (1).
// (RULE_17) SPI fault source is unmasked SPI error; UV/thermal is OR of faults.
// (RULE_18) Reserved bits 26:24, 20, 12 read reset value and ignore writes.
module mpc_config import mpc_pkg::*; #(
    parameter longint WD_C0  = WD_CYC_0,
    parameter longint WD_C1  = WD_CYC_1,
    parameter longint WD_C2  = WD_CYC_2,
    parameter longint WD_C3  = WD_CYC_3,
    parameter longint PULSE  = PULSE_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data,
    input  wire logic        wake_pin,
    input  wire logic        pin_one_in,
    input  wire logic        can_core_irq0,
    input  wire logic        can_core_irq1,
    input  wire logic        spi_fault_flag,
    input  wire logic        uv_fault,
    input  wire logic        thermal_fault,
    input  wire logic        irq_out_n,
    input  wire logic        wake_irq,
    input  wire logic        inhibit_on,
    output logic             wake_event_q,
    output logic             wdog_flag_q,
    output logic             standby_req_q,
    output logic             ref_is_40mhz_q,
    output logic             test_mode_q,
    output logic             fail_safe_en_q,
    output logic             wake_req_rail_select_q,
    output logic             sleep_control_out_q,
    output logic             wake_request_out_n_q,
    output logic             out_pin_two_q,
    output logic             out_pin_two_oe_n_q,
    output logic             multi_pin_one_q,
    output logic             multi_pin_one_oe_n_q
);
    // ------------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------------
    logic [1:0]  wake_edge_q, wd_period_q, out2_src_q, watchdog_timeout_action_q;
    logic [1:0]  pin1_func_q, pin1_src_q;
    logic        ref_freq_q, test_en_q, rail_q, kick_q, fail_q;
    logic        slp_dis_q, wake_func_q;
    logic [31:0] wd_cnt_q;
    logic        wake_s, pin1_s, wake_d1_q, pin1_d1_q;
    logic        slp_low, wdp_low;

    mpc_sync u_wake (.clk(clk), .reset_n(reset_n), .din(wake_pin),
                     .dout(wake_s));
    mpc_sync u_pin1 (.clk(clk), .reset_n(reset_n), .din(pin_one_in),
                     .dout(pin1_s));

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire host_kick   = wr_en && wr_data[WD_KICK_BIT];              // RULE_07
    wire pin1_trig   = (pin1_func_q == PIN1_TRIG)                  // RULE_12
                       && (pin1_s != pin1_d1_q);
    wire wd_restart  = host_kick || pin1_trig;
    wire [31:0] wd_limit =                                         // RULE_02
        (wd_period_q == 2'h0) ? 32'(WD_C0) :
        (wd_period_q == 2'h1) ? 32'(WD_C1) :
        (wd_period_q == 2'h2) ? 32'(WD_C2) : 32'(WD_C3);
    wire wd_expire   = (wd_cnt_q >= wd_limit - 32'h1) && !wd_restart;
    wire rise        = wake_s && !wake_d1_q;
    wire fall        = !wake_s && wake_d1_q;
    wire wake_hit    =                                             // RULE_01
        (wake_edge_q == EDGE_RISE) ? rise :
        (wake_edge_q == EDGE_FALL) ? fall :
        (wake_edge_q == EDGE_OFF)  ? 1'b0 : (rise || fall);
    wire start_slp   = wd_expire && (watchdog_timeout_action_q == ACT_SLEEP);     // RULE_10
    wire start_pin   = wd_expire && (watchdog_timeout_action_q == ACT_PIN);       // RULE_10
    // Watchdog output level: low while flag held under action 00
    wire wd_out_n    = !(wdp_low ||                                 // RULE_09
                         (wdog_flag_q && watchdog_timeout_action_q == ACT_FLAG));
    wire src_uvt_n   = !(uv_fault || thermal_fault);                // RULE_17
    wire pin1_src_n  =                                              // RULE_14
        (pin1_src_q == SRC_SPI)  ? !spi_fault_flag :                // RULE_17
        (pin1_src_q == SRC_CAN1) ? !can_core_irq1 :
        (pin1_src_q == SRC_UVT)  ? src_uvt_n : 1'b1;
    wire out2_d      =                                              // RULE_04
        (out2_src_q == OUT2_CAN0) ? !can_core_irq0 :
        (out2_src_q == OUT2_WDOG) ? wd_out_n :
        (out2_src_q == OUT2_IRQ)  ? irq_out_n : 1'b1;
    // Inhibit is released during the timeout pulse and when disabled
    wire slp_d       = inhibit_on && !slp_low && !slp_dis_q;        // RULE_15
    wire wkrq_d      = wake_func_q ? !wake_irq : !slp_d;            // RULE_16

    mpc_pulse #(.LEN(PULSE)) u_slp (.clk(clk), .reset_n(reset_n),
        .start(start_slp), .low_q(slp_low));
    mpc_pulse #(.LEN(PULSE)) u_wdp (.clk(clk), .reset_n(reset_n),
        .start(start_pin), .low_q(wdp_low));

    // ------------------------------------------------------------------
    // Read-back; reserved bits stay at their zero reset value
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0;                                            // RULE_18
        rd_data[WAKE_EDGE_LSB +: 2] = wake_edge_q;
        rd_data[WD_PERIOD_LSB +: 2] = wd_period_q;
        rd_data[REF_FREQ_BIT]       = ref_freq_q;
        rd_data[OUT2_SRC_LSB +: 2]  = out2_src_q;
        rd_data[TEST_EN_BIT]        = test_en_q;
        rd_data[RAIL_SEL_BIT]       = rail_q;
        rd_data[WD_KICK_BIT]        = kick_q;
        rd_data[WD_ACT_LSB +: 2]    = watchdog_timeout_action_q;
        rd_data[PIN1_FUNC_LSB +: 2] = pin1_func_q;
        rd_data[FAIL_SAFE_BIT]      = fail_q;
        rd_data[PIN1_SRC_LSB +: 2]  = pin1_src_q;
        rd_data[SLEEP_OFF_BIT]      = slp_dis_q;
        rd_data[WAKE_FUNC_BIT]      = wake_func_q;
    end

    // ------------------------------------------------------------------
    // Writable fields; reserved bits are never stored
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_edge_q <= WAKE_EDGE_RST;
            wd_period_q <= WD_PERIOD_RST;                           // RULE_02
            ref_freq_q  <= REF_FREQ_RST;                            // RULE_03
            out2_src_q  <= OUT2_SRC_RST;
            test_en_q   <= 1'b0;
            rail_q      <= 1'b0;
            watchdog_timeout_action_q <= WD_ACT_RST;
            pin1_func_q <= PIN1_FUNC_RST;
            fail_q      <= 1'b0;
            pin1_src_q  <= PIN1_SRC_RST;                            // RULE_14
            slp_dis_q   <= 1'b0;
            wake_func_q <= 1'b0;
        end else if (wr_en) begin
            wake_edge_q <= wr_data[WAKE_EDGE_LSB +: 2];
            wd_period_q <= wr_data[WD_PERIOD_LSB +: 2];
            ref_freq_q  <= wr_data[REF_FREQ_BIT];
            out2_src_q  <= wr_data[OUT2_SRC_LSB +: 2];
            test_en_q   <= wr_data[TEST_EN_BIT];                    // RULE_05
            rail_q      <= wr_data[RAIL_SEL_BIT];                   // RULE_06
            watchdog_timeout_action_q <= wr_data[WD_ACT_LSB +: 2];
            pin1_func_q <= wr_data[PIN1_FUNC_LSB +: 2];
            fail_q      <= wr_data[FAIL_SAFE_BIT];                  // RULE_13
            pin1_src_q  <= wr_data[PIN1_SRC_LSB +: 2];
            slp_dis_q   <= wr_data[SLEEP_OFF_BIT];
            wake_func_q <= wr_data[WAKE_FUNC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter and kick bit; a restart beats a same-cycle expiry
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_cnt_q <= 32'h0;
            kick_q   <= 1'b0;
        end else begin
            wd_cnt_q <= (wd_restart || wd_expire) ? 32'h0
                                                  : wd_cnt_q + 32'h1;
            // Self-clears after the restart, sets on expiry
            kick_q   <= wd_expire;                                  // RULE_07 RULE_08
        end
    end

    // ------------------------------------------------------------------
    // Event flags: the kick clear wins, as a restart suppresses the same-cycle expiry
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdog_flag_q   <= 1'b0;
            standby_req_q <= 1'b0;
            wake_event_q  <= 1'b0;
            wake_d1_q     <= 1'b0;
            pin1_d1_q     <= 1'b0;
        end else begin
            wdog_flag_q   <= wd_expire || (wdog_flag_q && !wd_restart); // RULE_11
            standby_req_q <= start_slp;                             // RULE_10
            wake_event_q  <= wake_hit;
            wake_d1_q     <= wake_s;
            pin1_d1_q     <= pin1_s;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_is_40mhz_q         <= REF_FREQ_RST;
            test_mode_q            <= 1'b0;
            fail_safe_en_q         <= 1'b0;
            wake_req_rail_select_q <= 1'b0;
            sleep_control_out_q    <= 1'b0;
            wake_request_out_n_q   <= 1'b1;
            out_pin_two_q          <= 1'b1;
            out_pin_two_oe_n_q     <= 1'b1;
            multi_pin_one_q        <= 1'b1;
            multi_pin_one_oe_n_q   <= 1'b1;
        end else begin
            ref_is_40mhz_q         <= ref_freq_q;                   // RULE_03
            test_mode_q            <= test_en_q;                    // RULE_05
            fail_safe_en_q         <= fail_q;                       // RULE_13
            wake_req_rail_select_q <= rail_q;                       // RULE_06
            sleep_control_out_q    <= slp_d;                        // RULE_15
            wake_request_out_n_q   <= wkrq_d;                       // RULE_16
            out_pin_two_q          <= out2_d;
            out_pin_two_oe_n_q     <= (out2_src_q == OUT2_NONE);    // RULE_04
            multi_pin_one_q        <= pin1_src_n;
            multi_pin_one_oe_n_q   <= (pin1_func_q != PIN1_OUT);    // RULE_12
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_kick_self_clear: assert property ( // RULE_07
        @(posedge clk) disable iff (!reset_n)
        host_kick |=> !kick_q)
        else $error("kick bit did not clear");
    a_expire_sets_kick: assert property ( // RULE_08
        @(posedge clk) disable iff (!reset_n)
        wd_expire |=> kick_q && wdog_flag_q)
        else $error("expiry did not set kick and flag");
    a_flag_every_timeout: assert property ( // RULE_11
        @(posedge clk) disable iff (!reset_n)
        wd_expire |=> wdog_flag_q)
        else $error("timeout flag missing");
    a_sleep_pulse_start: assert property ( // RULE_10
        @(posedge clk) disable iff (!reset_n)
        start_slp |=> standby_req_q ##1 !sleep_control_out_q)
        else $error("inhibit pulse missing");
    a_test_mode_follow: assert property ( // RULE_05
        @(posedge clk) disable iff (!reset_n)
        ##1 test_mode_q == $past(test_en_q))
        else $error("test mode wrong");
    a_sleep_disabled: assert property ( // RULE_15
        @(posedge clk) disable iff (!reset_n)
        slp_dis_q && $past(slp_dis_q) |=> !sleep_control_out_q)
        else $error("inhibit not disabled");
    a_wake_off: assert property ( // RULE_01
        @(posedge clk) disable iff (!reset_n)
        wake_edge_q == EDGE_OFF |=> !wake_event_q)
        else $error("wake seen while off");
    a_pin1_input: assert property ( // RULE_12
        @(posedge clk) disable iff (!reset_n)
        pin1_func_q == PIN1_TRIG |=> multi_pin_one_oe_n_q)
        else $error("pin one driven as input");
    // A trigger edge must win over a same-cycle expiry
    a_trig_restart: assert property ( // RULE_12
        @(posedge clk) disable iff (!reset_n)
        pin1_trig |=> wd_cnt_q == 32'h0 && !kick_q)
        else $error("pin trigger did not restart watchdog");
    a_reserved_zero: assert property ( // RULE_18
        @(posedge clk) disable iff (!reset_n)
        rd_data[26:24] == 3'h0 && !rd_data[20] && !rd_data[12])
        else $error("reserved bits nonzero");
endmodule // mpc_config

// [test/mpc_host.sv]
// Host-side model that writes the configuration register word
`timescale 1ns/1ps
module mpc_host (
    input  wire logic        clk,
    output logic             wr_en,
    output logic      [31:0] wr_data
);
    // --------------------------------------------------------------
    // Write cycle
    // --------------------------------------------------------------
    initial begin
        wr_en   = 1'b0;
        wr_data = 32'h00000000;
    end

    // Call just after a rising edge; one whole word per strobe
    task automatic write(input logic [31:0] v);
        wr_en   <= 1'b1;
        wr_data <= v;
        @(posedge clk);
        wr_en   <= 1'b0;
        // Released bus shows the inverse so stale data is never trusted
        wr_data <= ~v;
    endtask
endmodule // mpc_host

// [test/test_mode_pin_config_register.sv]
// Self-checking bench for the mode/pin configuration register
`timescale 1ns/1ps
module test_mode_pin_config_register import mpc_pkg::*;;
    logic        clk, reset_n, wr_en, wake_pin, pin_one_in;
    logic [31:0] wr_data, rd_data, w;
    logic        irq0, irq1, spi_f, uv_f, th_f, irq_n, wk_irq, slp_on;
    logic        wake_ev, wd_flag, stby, ref40, test_m, fs_en, rail;
    logic        slp, wkrq_n, o2, o2_oe_n, p1, p1_oe_n;
    logic [1:0]  s1, o2s, f1;
    int          n_fail, total_checks, n, st, lo2, lsl, i;
    int          seed = 32'h2ac96450;
    int          lim[4] = '{20, 40, 60, 80};

    mpc_host host_u (.clk(clk), .wr_en(wr_en), .wr_data(wr_data));

    // Short watchdog counts keep the run brief
    mpc_config #(.WD_C0(20), .WD_C1(40), .WD_C2(60), .WD_C3(80),
                 .PULSE(10)) dut_u (
        .clk(clk), .reset_n(reset_n), .wr_en(wr_en), .wr_data(wr_data),
        .rd_data(rd_data), .wake_pin(wake_pin), .pin_one_in(pin_one_in),
        .can_core_irq0(irq0), .can_core_irq1(irq1),
        .spi_fault_flag(spi_f), .uv_fault(uv_f), .thermal_fault(th_f),
        .irq_out_n(irq_n), .wake_irq(wk_irq), .inhibit_on(slp_on),
        .wake_event_q(wake_ev), .wdog_flag_q(wd_flag),
        .standby_req_q(stby), .ref_is_40mhz_q(ref40),
        .test_mode_q(test_m), .fail_safe_en_q(fs_en),
        .wake_req_rail_select_q(rail), .sleep_control_out_q(slp),
        .wake_request_out_n_q(wkrq_n), .out_pin_two_q(o2),
        .out_pin_two_oe_n_q(o2_oe_n), .multi_pin_one_q(p1),
        .multi_pin_one_oe_n_q(p1_oe_n));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // Writable bits only; kick reads back 0 once taken
    function automatic logic [31:0] exp_rd(input logic [31:0] v);
        return v & 32'hF8EBEF00;
    endfunction

    // Pin one drives the chosen source, active low
    function automatic logic exp_p1(input logic [1:0] s);
        if (s == SRC_SPI) return ~spi_f;
        if (s == SRC_CAN1) return ~irq1;
        return ~(uv_f | th_f);
    endfunction

    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict;
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0; reset_n = 1'b0; wake_pin = 1'b0; pin_one_in = 1'b0;
        {irq0, irq1, spi_f, uv_f, th_f, irq_n, wk_irq, slp_on} = 8'h04;
        n_fail = 0; total_checks = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk); #1;
        chk(rd_data, 32'hC8000400, "reset value");
        chk(32'({ref40, test_m, rail, fs_en}), 32'h8, "reset levels");
        // Kick before expiry keeps the flag down
        @(posedge clk);
        host_u.write(32'h1 << WD_KICK_BIT);
        repeat (15) @(posedge clk);
        host_u.write(32'h1 << WD_KICK_BIT);
        n = 0;
        repeat (15) begin @(posedge clk); #1; n += wd_flag; end
        chk(32'(n), 32'h0, "kick restart");
        chk(32'(rd_data[WD_KICK_BIT]), 32'h0, "kick clears");
        // Pin one edges in trigger mode keep restarting the watchdog
        @(posedge clk);
        host_u.write((32'(PIN1_TRIG) << PIN1_FUNC_LSB)
            | (32'h1 << WD_KICK_BIT));
        n = 0;
        repeat (4) begin
            @(posedge clk);
            pin_one_in <= ~pin_one_in;
            repeat (9) begin @(posedge clk); #1; n += wd_flag; end
        end
        chk(32'(n), 32'h0, "pin one trigger");
        // Random words with legal selector values
        for (i = 0; i < 24; i++) begin
            @(posedge clk);
            {irq0, irq1, spi_f, uv_f, th_f, irq_n, wk_irq, slp_on}
                <= 8'($random(seed));
            w = $random(seed);
            s1 = 2'(i % 3);
            o2s = 2'(i % 4);
            if (o2s == OUT2_WDOG) o2s = OUT2_IRQ;
            f1 = (i % 5 == 4) ? PIN1_TRIG : PIN1_OUT;
            w[PIN1_FUNC_LSB+:2] = f1;
            w[PIN1_SRC_LSB+:2] = s1;
            w[OUT2_SRC_LSB+:2] = o2s;
            w[WD_ACT_LSB+:2] = 2'(i % 3);
            w[WD_KICK_BIT] = 1'b1;
            host_u.write(w);
            repeat (3) @(posedge clk); #1;
            chk(rd_data, exp_rd(w), "read back");
            chk(32'({ref40, test_m, rail, fs_en}), 32'({w[REF_FREQ_BIT],
                w[TEST_EN_BIT], w[RAIL_SEL_BIT], w[FAIL_SAFE_BIT]}),
                "levels");
            chk(32'(slp), 32'(slp_on && !w[SLEEP_OFF_BIT]),
                "inhibit");
            if (w[WAKE_FUNC_BIT])
                chk(32'(wkrq_n), 32'(!wk_irq), "wkrq");
            else chk(32'(wkrq_n), 32'(!(slp_on && !w[SLEEP_OFF_BIT])),
                "wkrq copy");
            if (f1 == PIN1_TRIG) chk(32'(p1_oe_n), 32'h1, "p1 dir");
            else chk(32'({p1_oe_n, p1}), 32'(exp_p1(s1)), "p1");
            if (o2s == OUT2_NONE) chk(32'(o2_oe_n), 32'h1, "p2 off");
            else chk(32'({o2_oe_n, o2}), 32'((o2s == OUT2_CAN0) ? !irq0
                : irq_n), "p2");
        end
        // Timeout periods and actions, pin two shows the watchdog
        @(posedge clk);
        slp_on <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            host_u.write((32'(i) << WD_PERIOD_LSB) | (32'(i % 3)
                << WD_ACT_LSB) | (32'(OUT2_WDOG) << OUT2_SRC_LSB)
                | (32'h1 << WD_KICK_BIT));
            repeat (2) @(posedge clk); #1;
            n = 2;
            while (wd_flag !== 1'b1 && n < 200) begin
                @(posedge clk); #1; n++;
            end
            chk(32'(n >= lim[i] && n <= lim[i] + 2), 32'h1, "period");
            chk(32'(rd_data[WD_KICK_BIT]), 32'h1, "kick set");
            // Standby pulse stands only in the cycle the flag rises
            st = stby; lo2 = 0; lsl = 0;
            repeat (15) begin
                @(posedge clk); #1;
                st += stby; lo2 += !o2; lsl += !slp;
            end
            chk(32'(st), 32'(i % 3 == 1), "standby");
            chk(32'(lsl), (i % 3 == 1) ? 32'hA : 32'h0, "sleep pulse");
            if (i % 3 == 0) chk(32'(lo2 >= 14), 32'h1, "wd low");
            else chk(32'(lo2), (i % 3 == 2) ? 32'hA : 32'h0, "wd pulse");
        end
        // Wake edge modes: rise then fall for each
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            host_u.write((32'(i) << WAKE_EDGE_LSB) | (32'h1 << WD_KICK_BIT));
            n = 0;
            repeat (2) begin
                @(posedge clk);
                wake_pin <= ~wake_pin;
                repeat (8) begin @(posedge clk); #1; n += wake_ev; end
            end
            chk(32'(n), (i == 0) ? 32'h0 : (i == 3) ? 32'h2 : 32'h1, "wake");
        end
        print_verdict;
    end
endmodule // test_mode_pin_config_register
